// File: mscp_chk.sv
`timescale 1ns/1ps
module mscp_chk #(parameter int CFG_W = 16, parameter int MUX_W = 3) (
	input wire logic clk,
	input wire logic resetn,
	input wire logic module_select_n,
	input wire logic serial_shift_clock,
	input wire logic serial_in_line,
	input wire logic data_address_flag,
	input wire logic slot_zero_target_n,
	input wire logic scan_advance_clock,
	input wire logic output_route_jumper,
	input wire logic serial_out_line,
	input wire logic serial_out_oe,
	input wire logic [CFG_W-1:0] config_value,
	input wire logic [MUX_W-1:0] channel_mux_counter,
	input wire logic module_selected
);
	default clocking @(posedge clk); endclocking
	default disable iff (!resetn);
	property p_oe_sel; serial_out_oe |-> module_selected; endproperty
	a_oe_sel: assert property (p_oe_sel) else $error("oe while unselected");
	property p_oe_jmp; !output_route_jumper [*6] |-> !serial_out_oe; endproperty
	a_oe_jmp: assert property (p_oe_jmp) else $error("oe with jumper off");
	property p_hold; !module_selected && !$past(module_selected) |-> $stable(config_value); endproperty
	a_hold: assert property (p_hold) else $error("config moved unselected");
	property p_shift; $changed(config_value) |-> (config_value >> 1) == ($past(config_value) & ({CFG_W{1'b1}} >> 1)); endproperty
	a_shift: assert property (p_shift) else $error("config not a shift");
	property p_flag; $changed(config_value) |-> !data_address_flag; endproperty
	a_flag: assert property (p_flag) else $error("config written in address mode");
	property p_inc; $changed(channel_mux_counter) |-> channel_mux_counter == $past(channel_mux_counter) + 1'b1; endproperty
	a_inc: assert property (p_inc) else $error("counter step wrong");
	property p_scan; $rose(scan_advance_clock) |-> ##[2:8] $changed(channel_mux_counter); endproperty
	a_scan: assert property (p_scan) else $error("scan edge lost");
	property p_tgt; $fell(slot_zero_target_n) |-> ##[1:6] !module_selected; endproperty
	a_tgt: assert property (p_tgt) else $error("select kept");
	c_cfg: cover property ($changed(config_value));
	c_sel: cover property ($rose(module_selected));
	c_cnt: cover property ($changed(channel_mux_counter));
endmodule : mscp_chk
bind mscp_serial_port mscp_chk #(.CFG_W(CFG_W), .MUX_W(MUX_W)) i_mscp_chk (.*);

// File: mscp_daq_model.sv
`timescale 1ns/1ps
module mscp_daq_model (
	input wire logic clk,
	input wire logic serial_out_line,
	output logic module_select_n = 1'b1,
	output logic serial_shift_clock = 1'b1,
	output logic serial_in_line = 1'b0,
	output logic data_address_flag = 1'b1,
	output logic slot_zero_target_n = 1'b0
);
	task automatic half();
		repeat (6) @(posedge clk);
	endtask : half
	// With s low this is a slot-select write, so the chassis keeps the module unselected.
	task automatic xfer(input logic s, input logic f, input int n, input logic [39:0] din, output logic [39:0] q);
		q = '0;
		data_address_flag <= f;
		slot_zero_target_n <= s;
		module_select_n <= !s;
		half();
		for (int i = 0; i < n; i++) begin
			serial_in_line <= din[39-i];
			half();
			serial_shift_clock <= 1'b0;
			half();
			serial_shift_clock <= 1'b1;
			half();
			q[39-i] = serial_out_line;
		end
		slot_zero_target_n <= 1'b0;
		module_select_n <= 1'b1;
		half();
	endtask : xfer
endmodule : mscp_daq_model

// File: mscp_in_sync.sv
`timescale 1ns/1ps
module mscp_in_sync #(
	parameter logic INIT = 1'b0
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic async_in,
	output logic level,
	output logic rise,
	output logic fall
);
	logic [2:0] sh_q;
	logic [2:0] sh_d;
	logic level_q;
	logic level_d;

	// The first stage feeds only the second; agreement of stages two and three commits a change.
	always_comb begin
		sh_d = {sh_q[1:0], async_in};
		level_d = (sh_q[1] == sh_q[2]) ? sh_q[2] : level_q;
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			sh_q <= {3{INIT}};
			level_q <= INIT;
		end else begin
			sh_q <= sh_d;
			level_q <= level_d;
		end
	end

	assign level = level_q;
	assign rise = level_d & ~level_q;
	assign fall = ~level_d & level_q;
endmodule : mscp_in_sync

// File: mscp_pkg.sv
package mscp_pkg;
	localparam int MSCP_CFG_W = 16;
	localparam int MSCP_ID_W = 32;
	localparam int MSCP_MUX_W = 3;
	localparam logic [31:0] MSCP_ID_VALUE = 32'h00A5_5A01;
	localparam logic [15:0] MSCP_CFG_RESET = 16'h0000;
	localparam logic [2:0] MSCP_MUX_RESET = 3'h0;
	localparam int MSCP_SYNC_STAGES = 3;
	localparam int MSCP_LINK_PERIOD_NS = 48;
	localparam int MSCP_CLK_PERIOD_NS = 4;
	localparam int MSCP_MIN_LINK_CYCLES = MSCP_LINK_PERIOD_NS / MSCP_CLK_PERIOD_NS;
	localparam logic MSCP_FLAG_DATA = 1'b0;
	localparam logic MSCP_FLAG_ADDR = 1'b1;
	localparam logic MSCP_ROUTE_MODULE = 1'b1;
	localparam logic MSCP_JUMPER_BUS = 1'b1;
	typedef enum logic [1:0] {
		MSCP_IDLE = 2'b00,
		MSCP_ARMED = 2'b01,
		MSCP_ACTIVE = 2'b11
	} mscp_state_t;
endpackage : mscp_pkg

// File: mscp_serial_port.sv
`timescale 1ns/1ps
module mscp_serial_port
	import mscp_pkg::*;
#(
	parameter int CFG_W = mscp_pkg::MSCP_CFG_W,
	parameter int MUX_W = mscp_pkg::MSCP_MUX_W,
	parameter logic [31:0] ID_VALUE = mscp_pkg::MSCP_ID_VALUE
) (
	input wire logic clk,
	input wire logic resetn,
	input wire logic module_select_n,
	input wire logic serial_shift_clock,
	input wire logic serial_in_line,
	input wire logic data_address_flag,
	input wire logic slot_zero_target_n,
	input wire logic scan_advance_clock,
	input wire logic output_route_jumper,
	output logic serial_out_line,
	output logic serial_out_oe,
	output logic [CFG_W-1:0] config_value,
	output logic [MUX_W-1:0] channel_mux_counter,
	output logic module_selected
);
	import mscp_pkg::*;

	// The shift path needs at least two configuration bits; the reset values are cast to width.
	initial begin
		if (CFG_W < 2 || CFG_W > 64) begin
			$error("mscp_serial_port: configuration width out of range");
		end
		if (MUX_W < 1 || MUX_W > 16) begin
			$error("mscp_serial_port: counter width out of range");
		end
	end

	// Reset release is synchronised so every flop reset by rst_n leaves reset on the same edge.
	logic [1:0] rst_sync_q;
	logic [1:0] rst_sync_d;
	logic rst_n;

	always_comb begin
		rst_sync_d = {rst_sync_q[0], 1'b1};
	end

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			rst_sync_q <= 2'b00;
		end else begin
			rst_sync_q <= rst_sync_d;
		end
	end

	// Assertion of reset reaches the logic at once; only its release waits two edges.
	assign rst_n = rst_sync_q[1];

	logic sel_n_lvl;
	logic sclk_lvl;
	logic sclk_rise;
	logic sclk_fall;
	logic sdi_lvl;
	logic flag_lvl;
	logic tgt_lvl;
	logic scan_rise;
	logic jmp_lvl;

	// Each synchroniser but u_tgt and u_jmp starts at the idle level of its pin, so reset release shows no false edge.
	// The jumper is a pin as well and is treated like any other asynchronous input.
	mscp_in_sync #(
		.INIT(1'b1)
	) u_sel (
		.clk(clk),
		.rst_n(rst_n),
		.async_in(module_select_n),
		.level(sel_n_lvl),
		.rise(),
		.fall()
	);

	mscp_in_sync #(
		.INIT(1'b1)
	) u_sclk (
		.clk(clk),
		.rst_n(rst_n),
		.async_in(serial_shift_clock),
		.level(sclk_lvl),
		.rise(sclk_rise),
		.fall(sclk_fall)
	);

	mscp_in_sync #(
		.INIT(1'b0)
	) u_sdi (
		.clk(clk),
		.rst_n(rst_n),
		.async_in(serial_in_line),
		.level(sdi_lvl),
		.rise(),
		.fall()
	);

	mscp_in_sync #(
		.INIT(1'b1)
	) u_flag (
		.clk(clk),
		.rst_n(rst_n),
		.async_in(data_address_flag),
		.level(flag_lvl),
		.rise(),
		.fall()
	);

	mscp_in_sync #(
		.INIT(1'b1)
	) u_tgt (
		.clk(clk),
		.rst_n(rst_n),
		.async_in(slot_zero_target_n),
		.level(tgt_lvl),
		.rise(),
		.fall()
	);

	mscp_in_sync #(
		.INIT(1'b0)
	) u_scan (
		.clk(clk),
		.rst_n(rst_n),
		.async_in(scan_advance_clock),
		.level(),
		.rise(scan_rise),
		.fall()
	);

	mscp_in_sync #(
		.INIT(1'b0)
	) u_jmp (
		.clk(clk),
		.rst_n(rst_n),
		.async_in(output_route_jumper),
		.level(jmp_lvl),
		.rise(),
		.fall()
	);

	// Data, clock and flag all cross through equal-depth synchronisers, so data set up
	// before the falling edge is stable by the time the rising edge is seen.
	mscp_state_t state_q;
	mscp_state_t state_d;
	logic [CFG_W-1:0] cfg_q;
	logic [CFG_W-1:0] cfg_d;
	logic [MSCP_ID_W-1:0] id_q;
	logic [MSCP_ID_W-1:0] id_d;
	logic [5:0] id_cnt_q;
	logic [5:0] id_cnt_d;
	logic sdo_q;
	logic sdo_d;
	logic [MUX_W-1:0] mux_q;
	logic [MUX_W-1:0] mux_d;
	logic sel_active;
	logic shift_ok;

	// Select only counts while the target line routes data to modules.
	assign sel_active = ~sel_n_lvl & (tgt_lvl == MSCP_ROUTE_MODULE);

	always_comb begin
		state_d = state_q;
		unique case (state_q)
			MSCP_IDLE: begin
				// Shifting waits for a selection seen with the clock high.
				if (sel_active && sclk_lvl) begin
					state_d = MSCP_ARMED;
				end
			end
			MSCP_ARMED: begin
				// The first falling edge after selection arms the shift; the next rise loads a bit.
				if (!sel_active) begin
					state_d = MSCP_IDLE;
				end else if (sclk_fall) begin
					state_d = MSCP_ACTIVE;
				end
			end
			MSCP_ACTIVE: begin
				// Only deselection leaves this state, so every later clock is a transfer.
				if (!sel_active) begin
					state_d = MSCP_IDLE;
				end
			end
			default: begin
				state_d = MSCP_IDLE;
			end
		endcase
	end

	assign shift_ok = (state_q == MSCP_ACTIVE) && sel_active && sclk_rise;

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			state_q <= MSCP_IDLE;
		end else begin
			state_q <= state_d;
		end
	end

	// Once every identification bit has left, the line carries zeros until deselection.
	function automatic logic id_bit_out(input logic [MSCP_ID_W-1:0] word, input logic [5:0] count);
		return (count < 6'(MSCP_ID_W)) ? word[MSCP_ID_W-1] : 1'b0;
	endfunction : id_bit_out

	// A data cycle shifts the configuration register; address cycles leave it alone.
	always_comb begin
		cfg_d = cfg_q;
		if (shift_ok && flag_lvl == MSCP_FLAG_DATA) begin
			cfg_d = {cfg_q[CFG_W-2:0], sdi_lvl};
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			cfg_q <= CFG_W'(MSCP_CFG_RESET);
		end else begin
			cfg_q <= cfg_d;
		end
	end

	// The identification word moves on every clock whatever the flag says, so a host
	// that reads with the flag high still sees the readout advance.
	always_comb begin
		id_d = id_q;
		id_cnt_d = id_cnt_q;
		sdo_d = sdo_q;
		if (!sel_active) begin
			// Deselection rearms the readout from its first bit.
			id_d = ID_VALUE;
			id_cnt_d = 6'h00;
			sdo_d = 1'b0;
		end else if (shift_ok) begin
			// A bit leaves on its clock, so the host finds it once the clock is back high.
			id_d = {id_q[MSCP_ID_W-2:0], 1'b0};
			if (id_cnt_q < 6'(MSCP_ID_W)) begin
				id_cnt_d = id_cnt_q + 6'h01;
			end
			sdo_d = id_bit_out(id_q, id_cnt_q);
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			id_q <= ID_VALUE;
			id_cnt_q <= 6'h00;
			sdo_q <= 1'b0;
		end else begin
			id_q <= id_d;
			id_cnt_q <= id_cnt_d;
			sdo_q <= sdo_d;
		end
	end

	// Scanning is independent of the serial port, so the counter runs even when deselected.
	always_comb begin
		mux_d = mux_q;
		if (scan_rise) begin
			mux_d = mux_q + MUX_W'(1);
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			mux_q <= MUX_W'(MSCP_MUX_RESET);
		end else begin
			mux_q <= mux_d;
		end
	end

	// Drive the bus line only when routed there and addressed, so other modules may share it.
	assign serial_out_line = sdo_q;
	assign serial_out_oe = (jmp_lvl == MSCP_JUMPER_BUS) && sel_active;
	assign config_value = cfg_q;
	assign channel_mux_counter = mux_q;
	assign module_selected = sel_active;
endmodule : mscp_serial_port

// File: test_module_serial_config_port.sv
`timescale 1ns/1ps
module test_module_serial_config_port;
	import mscp_pkg::*;
	logic clk = 1'b0, resetn = 1'b0, output_route_jumper = 1'b1, scan_advance_clock = 1'b0;
	logic module_select_n, serial_shift_clock, serial_in_line, data_address_flag, slot_zero_target_n;
	logic serial_out_line, serial_out_oe, module_selected;
	logic [15:0] config_value, d;
	logic [2:0] channel_mux_counter;
	logic [39:0] rd;
	int n_errors = 0, checks_done = 0, k;
	always #2 clk = ~clk;
	mscp_serial_port i_mscp_serial_port (.*);
	mscp_daq_model i_mscp_daq_model (.*);
	task automatic chk(input string s, input logic [39:0] seen, exp);
		checks_done++;
		if (seen !== exp) begin
			n_errors++;
			$display("CHECK FAILED %s expected %h seen %h", s, exp, seen);
		end
	endtask : chk
	task automatic conclude();
		$display("errors %0d checks %0d", n_errors, checks_done);
		if (n_errors == 0 && checks_done > 0) $display("RESULT: PASS");
		else $display("RESULT: FAIL");
		$finish;
	endtask : conclude
	function automatic logic [39:0] exp_id(int n);
		return {MSCP_ID_VALUE, 8'h00} >> (40 - n) << (40 - n);
	endfunction : exp_id
	initial begin
		k = $urandom(62434);
		repeat (6) @(posedge clk);
		resetn <= 1'b1;
		repeat (10) @(posedge clk);
		for (int t = 0; t < 3; t++) begin
			d = t == 0 ? 16'h8001 : 16'($urandom());
			i_mscp_daq_model.xfer(1'b1, 1'b0, 16, {d, 24'h0}, rd);
			chk("config", config_value, d);
			i_mscp_daq_model.xfer(1'b0, 1'b0, 16, {~d, 24'h0}, rd);
			chk("config", config_value, d);
		end
		// The short second read runs with the jumper off and checks only the identification word's zero top byte.
		for (int j = 0; j < 2; j++) begin
			output_route_jumper <= !j[0];
			fork
				i_mscp_daq_model.xfer(1'b1, 1'b1, j ? 8 : 40, '0, rd);
				#201 begin
					chk("oe", serial_out_oe, !j[0]);
					chk("selected", module_selected, 1'b1);
				end
			join
			chk("selected", module_selected, 1'b0);
			chk("id", rd, exp_id(j ? 8 : 40));
			chk("config", config_value, d);
		end
		i_mscp_daq_model.xfer(1'b0, 1'b0, 16, '0, rd);
		chk("config", config_value, d);
		k = $urandom_range(9, 1);
		repeat (k) begin
			scan_advance_clock <= 1'b1;
			repeat (6) @(posedge clk);
			scan_advance_clock <= 1'b0;
			repeat (6) @(posedge clk);
		end
		chk("counter", channel_mux_counter, 3'(k));
		resetn <= 1'b0;
		repeat (6) @(posedge clk);
		chk("config", config_value, '0);
		chk("counter", channel_mux_counter, '0);
		conclude();
	end
	initial begin
		#100000;
		n_errors++;
		conclude();
	end
endmodule : test_module_serial_config_port
